// [rtl/command_table_descriptor_walker.sv]
/*
 * Per-port command slot walker: fetches the command frame, optional packet
 * command and scatter/gather list of one command table, sends the frame and
 * packet command to the link, and hands each data block to a data mover.
 * Assumes a single-outstanding memory read port and an external data mover.
 */
`timescale 1ns/100ps
// What this block does
// - keep a 32-bit count of bytes moved for the command, either direction.
// - table base from table low register bits 31:7; low seven bits ignored.
// - frame at 00h, packet command at 40h, descriptor list at 80h.
// - set task-file busy before sending the command frame.
// - frame sent as built; no port number inserted by hardware.
// - packet command sent only when the header packet flag is set.
// - packet command length taken from the drive's setup request.
// - list holds 0 to 65535 entries; zero entries moves no data.
// - descriptors processed in ascending order, 0 through count minus one.
// - block address from bits 31:1 of word 0; bit 0 ignored.
// - upper block address used only when wide addressing is enabled.
// - completion bit raises descriptor-processed flag and interrupt if enabled.
// - completion may be reported while data still travels downstream.
// - block length is field 21:0 plus one byte.
// - stop fetching after header entry count entries of four words.
// - packet flag means expect drive setup request; prefetch packet command.
// - header bit 6 picks direction: set to drive, clear to memory.
module command_table_descriptor_walker (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	output logic mem_req_out,
	output logic [63:0] mem_addr_out,
	input wire logic mem_rvalid_in,
	input wire logic [31:0] mem_rdata_in,
	output logic tx_valid_out,
	output logic [31:0] tx_data_out,
	output logic tx_last_out,
	input wire logic tx_ready_in,
	input wire logic pio_req_in,
	input wire logic [4:0] pio_len_in,
	output logic xfer_start_out,
	output logic [63:0] xfer_addr_out,
	output logic [22:0] xfer_len_out,
	output logic xfer_to_drive_out,
	input wire logic xfer_done_in,
	output logic task_file_busy_flag_out,
	output logic descriptor_processed_status_out,
	output logic dps_irq_out,
	output logic [31:0] transferred_byte_tally_out
);
	walker_pkg::walker_state_s s_r;
	walker_pkg::walker_state_s s_nxt;
	logic buf_wr;
	logic [walker_pkg::BUF_AW-1:0] buf_wr_addr;
	logic buf_rd;
	logic [walker_pkg::BUF_AW-1:0] buf_rd_addr;
	logic [63:0] table_base;
	logic [63:0] fetch_addr;
	logic [15:0] entry_count;
	logic [4:0] frame_words;
	logic packet_mode;
	logic [4:0] cnt_inc;
	logic [15:0] idx_inc;

	// ==========================================================
	// helpers
	frame_buffer u_buf (
		.clk_in(clk_in),
		.wr_en_in(buf_wr),
		.wr_addr_in(buf_wr_addr),
		.wr_data_in(mem_rdata_in),
		.rd_en_in(buf_rd),
		.rd_addr_in(buf_rd_addr),
		.rd_data_out(tx_data_out)
	);

	byte_tally u_tally (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.clear_in(s_r.tally_clr),
		.add_in(s_r.tally_add),
		.amount_in(s_r.xfer.len),
		.tally_out(transferred_byte_tally_out)
	);

	// ==========================================================
	// address and header decode
	always_comb begin
		entry_count = s_r.header0[walker_pkg::HDR_COUNT_MSB:walker_pkg::HDR_COUNT_LSB];
		frame_words = s_r.header0[walker_pkg::HDR_FRAME_LEN_MSB:0];
		packet_mode = s_r.header0[walker_pkg::HDR_PACKET_BIT];
		cnt_inc = 5'(s_r.cnt + 5'h01);
		idx_inc = 16'(s_r.idx + 16'h0001);
		table_base = {(s_r.wide ? s_r.table_high : 32'h00000000),
			s_r.table_low[31:walker_pkg::TABLE_BASE_LSB],
			{walker_pkg::TABLE_BASE_LSB{1'b0}}};
		case (s_r.phase)
			walker_pkg::PH_PACKET: begin
				fetch_addr = table_base + walker_pkg::PACKET_OFFSET
					+ (64'(s_r.cnt) << walker_pkg::WORD_SHIFT);
			end
			walker_pkg::PH_DESC: begin
				fetch_addr = table_base + walker_pkg::LIST_OFFSET
					+ (64'(s_r.idx) << walker_pkg::ENTRY_SHIFT)
					+ (64'(s_r.cnt) << walker_pkg::WORD_SHIFT);
			end
			default: begin
				fetch_addr = table_base + walker_pkg::FRAME_OFFSET
					+ (64'(s_r.cnt) << walker_pkg::WORD_SHIFT);
			end
		endcase
	end

	// ==========================================================
	// registers and walk sequence
	always_comb begin
		s_nxt = s_r;
		s_nxt.mem.req = 1'b0;
		s_nxt.xfer.start = 1'b0;
		s_nxt.tally_clr = 1'b0;
		s_nxt.tally_add = 1'b0;
		s_nxt.rdata = 32'h00000000;
		buf_wr = 1'b0;
		buf_wr_addr = 5'(((s_r.phase == walker_pkg::PH_PACKET) ?
			walker_pkg::PACKET_SLOT : walker_pkg::FRAME_SLOT) + s_r.cnt);
		buf_rd = 1'b0;
		buf_rd_addr = 5'(((s_r.phase == walker_pkg::PH_PACKET) ?
			walker_pkg::PACKET_SLOT : walker_pkg::FRAME_SLOT) + s_r.cnt);

		if (reg_rd_in) begin
			case (reg_addr_in)
				walker_pkg::REG_CTRL: begin
					s_nxt.rdata[walker_pkg::CTRL_WIDE_BIT] = s_r.wide;
					s_nxt.rdata[walker_pkg::CTRL_DPS_EN_BIT] = s_r.dps_en;
				end
				walker_pkg::REG_STATUS: begin
					s_nxt.rdata[walker_pkg::STAT_ENGINE_BIT] = (s_r.state != walker_pkg::ST_IDLE);
					s_nxt.rdata[walker_pkg::STAT_TF_BUSY_BIT] = s_r.tf_busy;
					s_nxt.rdata[walker_pkg::STAT_DPS_BIT] = s_r.dps;
					s_nxt.rdata[walker_pkg::STAT_DONE_BIT] = s_r.done;
				end
				walker_pkg::REG_HEADER0: s_nxt.rdata = s_r.header0;
				walker_pkg::REG_TALLY: s_nxt.rdata = transferred_byte_tally_out;
				walker_pkg::REG_TABLE_LOW: s_nxt.rdata = s_r.table_low;
				walker_pkg::REG_TABLE_HIGH: s_nxt.rdata = s_r.table_high;
				walker_pkg::REG_ENTRY_INDEX: s_nxt.rdata = {16'h0000, s_r.idx};
				default: s_nxt.rdata = 32'h00000000;
			endcase
		end

		// clears first so a same-cycle set below wins
		if (reg_wr_in) begin
			case (reg_addr_in)
				walker_pkg::REG_CTRL: begin
					s_nxt.wide = reg_wdata_in[walker_pkg::CTRL_WIDE_BIT];
					s_nxt.dps_en = reg_wdata_in[walker_pkg::CTRL_DPS_EN_BIT];
				end
				walker_pkg::REG_STATUS: begin
					if (reg_wdata_in[walker_pkg::STAT_DPS_BIT]) begin
						s_nxt.dps = 1'b0;
					end
					if (reg_wdata_in[walker_pkg::STAT_DONE_BIT]) begin
						s_nxt.done = 1'b0;
					end
				end
				walker_pkg::REG_HEADER0: begin
					if (s_r.state == walker_pkg::ST_IDLE) begin
						s_nxt.header0 = reg_wdata_in;
					end
				end
				walker_pkg::REG_TABLE_LOW: begin
					if (s_r.state == walker_pkg::ST_IDLE) begin
						s_nxt.table_low = reg_wdata_in;
					end
				end
				walker_pkg::REG_TABLE_HIGH: begin
					if (s_r.state == walker_pkg::ST_IDLE) begin
						s_nxt.table_high = reg_wdata_in;
					end
				end
				default: begin
				end
			endcase
		end

		case (s_r.state)
			walker_pkg::ST_IDLE: begin
				if (reg_wr_in && reg_addr_in == walker_pkg::REG_CTRL
					&& reg_wdata_in[walker_pkg::CTRL_GO_BIT]) begin
					s_nxt.tally_clr = 1'b1;
					s_nxt.tf_busy = 1'b1;
					s_nxt.phase = walker_pkg::PH_FRAME;
					s_nxt.cnt = 5'h00;
					s_nxt.idx = 16'h0000;
					s_nxt.total = frame_words;
					s_nxt.state = walker_pkg::ST_FETCH_REQ;
				end
			end
			walker_pkg::ST_FETCH_REQ: begin
				s_nxt.mem.req = 1'b1;
				s_nxt.mem.addr = fetch_addr;
				s_nxt.state = walker_pkg::ST_FETCH_WAIT;
			end
			walker_pkg::ST_FETCH_WAIT: begin
				if (mem_rvalid_in) begin
					if (s_r.phase == walker_pkg::PH_DESC) begin
						case (s_r.cnt[1:0])
							walker_pkg::DESC_WORD_ADDR_LOW: s_nxt.blk_low = mem_rdata_in;
							walker_pkg::DESC_WORD_ADDR_HIGH: s_nxt.blk_high = mem_rdata_in;
							walker_pkg::DESC_WORD_INFO: s_nxt.blk_info = mem_rdata_in;
							default: begin
							end
						endcase
					end else begin
						buf_wr = 1'b1;
					end
					if (cnt_inc == s_r.total) begin
						s_nxt.cnt = 5'h00;
						case (s_r.phase)
							walker_pkg::PH_FRAME: begin
								if (packet_mode) begin
									s_nxt.phase = walker_pkg::PH_PACKET;
									s_nxt.total = walker_pkg::PACKET_WORDS;
									s_nxt.state = walker_pkg::ST_FETCH_REQ;
								end else begin
									s_nxt.state = walker_pkg::ST_SEND_RD;
								end
							end
							walker_pkg::PH_PACKET: begin
								s_nxt.phase = walker_pkg::PH_FRAME;
								s_nxt.total = frame_words;
								s_nxt.state = walker_pkg::ST_SEND_RD;
							end
							default: s_nxt.state = walker_pkg::ST_XFER_REQ;
						endcase
					end else begin
						s_nxt.cnt = cnt_inc;
						s_nxt.state = walker_pkg::ST_FETCH_REQ;
					end
				end
			end
			walker_pkg::ST_SEND_RD: begin
				buf_rd = 1'b1;
				s_nxt.tx.valid = 1'b1;
				s_nxt.tx.last = (cnt_inc == s_r.total);
				s_nxt.state = walker_pkg::ST_SEND_HOLD;
			end
			walker_pkg::ST_SEND_HOLD: begin
				if (tx_ready_in) begin
					s_nxt.tx.valid = 1'b0;
					s_nxt.tx.last = 1'b0;
					if (s_r.tx.last) begin
						s_nxt.cnt = 5'h00;
						if (s_r.phase == walker_pkg::PH_FRAME && packet_mode) begin
							s_nxt.state = walker_pkg::ST_PIO_WAIT;
						end else if (entry_count == 16'h0000) begin
							s_nxt.tf_busy = 1'b0;
							s_nxt.done = 1'b1;
							s_nxt.state = walker_pkg::ST_IDLE;
						end else begin
							s_nxt.phase = walker_pkg::PH_DESC;
							s_nxt.total = walker_pkg::DESC_WORDS;
							s_nxt.state = walker_pkg::ST_FETCH_REQ;
						end
					end else begin
						s_nxt.cnt = cnt_inc;
						s_nxt.state = walker_pkg::ST_SEND_RD;
					end
				end
			end
			walker_pkg::ST_PIO_WAIT: begin
				if (pio_req_in) begin
					s_nxt.phase = walker_pkg::PH_PACKET;
					s_nxt.total = 5'(pio_len_in >> walker_pkg::WORD_SHIFT);
					s_nxt.cnt = 5'h00;
					s_nxt.state = walker_pkg::ST_SEND_RD;
				end
			end
			walker_pkg::ST_XFER_REQ: begin
				s_nxt.xfer.start = 1'b1;
				s_nxt.xfer.addr = {(s_r.wide ? s_r.blk_high : 32'h00000000),
					s_r.blk_low[31:walker_pkg::BLOCK_ADDR_LSB], 1'b0};
				s_nxt.xfer.len = 23'(s_r.blk_info[walker_pkg::DESC_LEN_MSB:0])
					+ 23'h000001;
				s_nxt.xfer.to_drive = s_r.header0[walker_pkg::HDR_WRITE_BIT];
				s_nxt.state = walker_pkg::ST_XFER_WAIT;
			end
			walker_pkg::ST_XFER_WAIT: begin
				if (xfer_done_in) begin
					s_nxt.tally_add = 1'b1;
					if (s_r.blk_info[walker_pkg::DESC_IOC_BIT]) begin
						s_nxt.dps = 1'b1;
					end
					s_nxt.cnt = 5'h00;
					if (idx_inc == entry_count) begin
						s_nxt.tf_busy = 1'b0;
						s_nxt.done = 1'b1;
						s_nxt.state = walker_pkg::ST_IDLE;
					end else begin
						s_nxt.idx = idx_inc;
						s_nxt.state = walker_pkg::ST_FETCH_REQ;
					end
				end
			end
			default: s_nxt.state = walker_pkg::ST_IDLE;
		endcase
		s_nxt.irq = s_nxt.dps & s_nxt.dps_en;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			s_r <= '0;
			s_r.state <= walker_pkg::ST_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// outputs
	always_comb begin
		reg_rdata_out = s_r.rdata;
		mem_req_out = s_r.mem.req;
		mem_addr_out = s_r.mem.addr;
		tx_valid_out = s_r.tx.valid;
		tx_last_out = s_r.tx.last;
		xfer_start_out = s_r.xfer.start;
		xfer_addr_out = s_r.xfer.addr;
		xfer_len_out = s_r.xfer.len;
		xfer_to_drive_out = s_r.xfer.to_drive;
		task_file_busy_flag_out = s_r.tf_busy;
		descriptor_processed_status_out = s_r.dps;
		dps_irq_out = s_r.irq;
	end
endmodule : command_table_descriptor_walker

// [rtl/walker_pkg.sv]
/*
 * Shared constants and types for the command table walker: register map,
 * header and descriptor field positions, table offsets, state and carrier structs.
 * Assumes one clock domain and a plain strobe register port.
 */
package walker_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_HEADER0 = 8'h08;
	localparam logic [7:0] REG_TALLY = 8'h0C;
	localparam logic [7:0] REG_TABLE_LOW = 8'h10;
	localparam logic [7:0] REG_TABLE_HIGH = 8'h14;
	localparam logic [7:0] REG_ENTRY_INDEX = 8'h18;

	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_WIDE_BIT = 1;
	localparam int CTRL_DPS_EN_BIT = 2;
	localparam int STAT_ENGINE_BIT = 0;
	localparam int STAT_TF_BUSY_BIT = 1;
	localparam int STAT_DPS_BIT = 2;
	localparam int STAT_DONE_BIT = 3;

	// ==========================================================
	// command header and descriptor fields
	localparam int HDR_COUNT_MSB = 31;
	localparam int HDR_COUNT_LSB = 16;
	localparam int HDR_WRITE_BIT = 6;
	localparam int HDR_PACKET_BIT = 5;
	localparam int HDR_FRAME_LEN_MSB = 4;
	localparam int TABLE_BASE_LSB = 7;
	localparam int BLOCK_ADDR_LSB = 1;
	localparam int DESC_IOC_BIT = 31;
	localparam int DESC_LEN_MSB = 21;
	localparam logic [1:0] DESC_WORD_ADDR_LOW = 2'h0;
	localparam logic [1:0] DESC_WORD_ADDR_HIGH = 2'h1;
	localparam logic [1:0] DESC_WORD_INFO = 2'h3;

	// ==========================================================
	// command table layout
	localparam logic [63:0] FRAME_OFFSET = 64'h0000000000000000;
	localparam logic [63:0] PACKET_OFFSET = 64'h0000000000000040;
	localparam logic [63:0] LIST_OFFSET = 64'h0000000000000080;
	localparam int WORD_SHIFT = 2;
	localparam int ENTRY_SHIFT = 4;
	localparam logic [4:0] DESC_WORDS = 5'h04;

	// ==========================================================
	// frame buffer
	localparam int BUF_AW = 5;
	localparam int BUF_DEPTH = 32;
	localparam logic [4:0] FRAME_SLOT = 5'h00;
	localparam logic [4:0] PACKET_SLOT = 5'h10;
	localparam logic [4:0] PACKET_WORDS = 5'h04;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		PH_FRAME = 2'h0,
		PH_PACKET = 2'h1,
		PH_DESC = 2'h2
	} phase_e;

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_FETCH_REQ = 8'h02,
		ST_FETCH_WAIT = 8'h04,
		ST_SEND_RD = 8'h08,
		ST_SEND_HOLD = 8'h10,
		ST_PIO_WAIT = 8'h20,
		ST_XFER_REQ = 8'h40,
		ST_XFER_WAIT = 8'h80
	} walk_state_e;

	typedef struct packed {
		logic req;
		logic [63:0] addr;
	} mem_req_s;

	typedef struct packed {
		logic start;
		logic [63:0] addr;
		logic [22:0] len;
		logic to_drive;
	} xfer_req_s;

	typedef struct packed {
		logic valid;
		logic last;
	} tx_ctl_s;

	typedef struct packed {
		walk_state_e state;
		phase_e phase;
		logic [4:0] cnt;
		logic [4:0] total;
		logic [15:0] idx;
		logic [31:0] blk_low;
		logic [31:0] blk_high;
		logic [31:0] blk_info;
		logic wide;
		logic dps_en;
		logic [31:0] header0;
		logic [31:0] table_low;
		logic [31:0] table_high;
		logic tf_busy;
		logic dps;
		logic done;
		logic irq;
		logic tally_clr;
		logic tally_add;
		logic [31:0] rdata;
		mem_req_s mem;
		xfer_req_s xfer;
		tx_ctl_s tx;
	} walker_state_s;

endpackage : walker_pkg

// [rtl/frame_buffer.sv]
/*
 * Small word store holding the command frame and the packet command.
 * Assumes one writer and one reader, read data registered.
 */
`timescale 1ns/100ps
module frame_buffer (
	input wire logic clk_in,
	input wire logic wr_en_in,
	input wire logic [walker_pkg::BUF_AW-1:0] wr_addr_in,
	input wire logic [31:0] wr_data_in,
	input wire logic rd_en_in,
	input wire logic [walker_pkg::BUF_AW-1:0] rd_addr_in,
	output logic [31:0] rd_data_out
);
	logic [31:0] mem_r [walker_pkg::BUF_DEPTH];

	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem_r[wr_addr_in] <= wr_data_in;
		end
		if (rd_en_in) begin
			rd_data_out <= mem_r[rd_addr_in];
		end
	end
endmodule : frame_buffer

// [rtl/byte_tally.sv]
/*
 * Running count of bytes moved for the current command.
 * Assumes clear and add never collide except at command start.
 */
`timescale 1ns/100ps
module byte_tally (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic clear_in,
	input wire logic add_in,
	input wire logic [22:0] amount_in,
	output logic [31:0] tally_out
);
	always_ff @(posedge clk_in) begin
		if (reset_in || clear_in) begin
			tally_out <= 32'h00000000;
		end else if (add_in) begin
			tally_out <= tally_out + 32'(amount_in);
		end
	end
endmodule : byte_tally

// [tb/walker_sva.sv]
/*
 * Port checker for the command table walker, bound to its top module.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/100ps
module walker_sva (
	input logic clk_in,
	input logic reset_in,
	input logic mem_req_out,
	input logic [63:0] mem_addr_out,
	input logic mem_rvalid_in,
	input logic tx_valid_out,
	input logic [31:0] tx_data_out,
	input logic tx_last_out,
	input logic tx_ready_in,
	input logic xfer_start_out,
	input logic [63:0] xfer_addr_out,
	input logic [22:0] xfer_len_out,
	input logic xfer_done_in,
	input logic task_file_busy_flag_out,
	input logic descriptor_processed_status_out,
	input logic dps_irq_out,
	input logic [31:0] transferred_byte_tally_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);
	// ==========================================================
	// assertions
	property p_busy_tx;
		tx_valid_out |-> task_file_busy_flag_out;
	endproperty
	a_busy_tx: assert property (p_busy_tx) else $error("word sent while not busy");
	property p_tx_hold;
		tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out) && $stable(tx_last_out);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("frame word changed before accept");
	property p_req_space;
		mem_req_out || mem_rvalid_in |=> !mem_req_out;
	endproperty
	a_req_space: assert property (p_req_space) else $error("memory read too early");
	property p_req_align;
		mem_req_out |-> mem_addr_out[1:0] == 2'h0;
	endproperty
	a_req_align: assert property (p_req_align) else $error("table read not word aligned");
	property p_start_busy;
		xfer_start_out |-> task_file_busy_flag_out ##1 !xfer_start_out;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("block start out of place");
	property p_xfer_shape;
		xfer_start_out |-> !xfer_addr_out[0] && !xfer_len_out[0] && xfer_len_out != 23'h0
			&& xfer_len_out <= 23'h400000;
	endproperty
	a_xfer_shape: assert property (p_xfer_shape) else $error("bad block shape");
	property p_tally_cause;
		transferred_byte_tally_out != $past(transferred_byte_tally_out)
			&& transferred_byte_tally_out != 32'h0
			|-> ($past(xfer_done_in) || $past(xfer_done_in, 2))
			&& transferred_byte_tally_out > $past(transferred_byte_tally_out);
	endproperty
	a_tally_cause: assert property (p_tally_cause) else $error("tally moved without block");
	property p_dps_cause;
		$rose(descriptor_processed_status_out) |-> $past(xfer_done_in) || $past(xfer_done_in, 2);
	endproperty
	a_dps_cause: assert property (p_dps_cause) else $error("flag raised without block");
	property p_irq_flag;
		dps_irq_out |-> descriptor_processed_status_out || $past(descriptor_processed_status_out);
	endproperty
	a_irq_flag: assert property (p_irq_flag) else $error("interrupt without flag");
	// ==========================================================
	// coverage
	c_tx_last: cover property (tx_valid_out && tx_ready_in && tx_last_out);
	c_xfer: cover property (xfer_start_out);
	c_irq: cover property (dps_irq_out);
endmodule : walker_sva

bind command_table_descriptor_walker walker_sva i_sva (.*);

// [tb/walker_host_model.sv]
/*
 * Far side model: system memory, link receiver and data mover.
 * Assumes the bench loads mem, pkt_en, pkt_len and frames between commands.
 */
`timescale 1ns/100ps
module walker_host_model (
	input logic clk_in,
	input logic mem_req_in,
	input logic [63:0] mem_addr_in,
	output logic mem_rvalid_out,
	output logic [31:0] mem_rdata_out,
	input logic tx_valid_in,
	input logic tx_last_in,
	output logic tx_ready_out,
	output logic pio_req_out,
	output logic [4:0] pio_len_out,
	input logic xfer_start_in,
	output logic xfer_done_out
);
	logic [31:0] mem [logic [63:0]];
	logic [63:0] rd_addr = 64'h0;
	logic pkt_en = 1'b0;
	logic [4:0] pkt_len = 5'h0C;
	int frames = 0;
	int rd_wait = 0;
	int pio_wait = 0;
	int xf_wait = 0;
	initial begin
		mem_rvalid_out = 1'b0;
		mem_rdata_out = 32'h0;
		tx_ready_out = 1'b0;
		pio_req_out = 1'b0;
		pio_len_out = 5'h0;
		xfer_done_out = 1'b0;
	end
	always @(posedge clk_in) begin
		mem_rvalid_out <= 1'b0;
		mem_rdata_out <= ~mem_rdata_out;
		pio_req_out <= 1'b0;
		pio_len_out <= ~pio_len_out;
		xfer_done_out <= 1'b0;
		tx_ready_out <= $urandom_range(3, 0) != 0;
		if (mem_req_in) begin
			rd_addr <= mem_addr_in;
			rd_wait <= $urandom_range(3, 1);
		end else if (rd_wait != 0) begin
			rd_wait <= rd_wait - 1;
			if (rd_wait == 1) begin
				mem_rvalid_out <= 1'b1;
				mem_rdata_out <= mem.exists(rd_addr) ? mem[rd_addr] : ~rd_addr[31:0];
			end
		end
		// setup request once the command frame has gone
		if (tx_valid_in && tx_ready_out && tx_last_in) begin
			frames <= frames + 1;
			if (frames == 0 && pkt_en) pio_wait <= 3;
		end
		if (pio_wait != 0) begin
			pio_wait <= pio_wait - 1;
			if (pio_wait == 1) begin
				pio_req_out <= 1'b1;
				pio_len_out <= pkt_len;
			end
		end
		if (xfer_start_in) xf_wait <= $urandom_range(4, 1);
		else if (xf_wait != 0) begin
			xf_wait <= xf_wait - 1;
			if (xf_wait == 1) xfer_done_out <= 1'b1;
		end
	end
endmodule : walker_host_model

// [tb/command_table_descriptor_walker_bench.sv]
/*
 * Self-checking bench: builds command tables in the model memory, runs
 * corner and random commands, checks link words, blocks and registers.
 */
`timescale 1ns/100ps
module command_table_descriptor_walker_bench;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [7:0] reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [31:0] reg_rdata_out, mem_rdata_in, tx_data_out, transferred_byte_tally_out;
	logic [63:0] mem_addr_out, xfer_addr_out;
	logic [22:0] xfer_len_out;
	logic [4:0] pio_len_in;
	logic mem_req_out, mem_rvalid_in, tx_valid_out, tx_last_out, tx_ready_in, pio_req_in;
	logic xfer_start_out, xfer_to_drive_out, xfer_done_in, task_file_busy_flag_out;
	logic descriptor_processed_status_out, dps_irq_out;
	int num_errors = 0;
	int checked = 0;
	logic [32:0] tx_q[$];
	logic [87:0] xf_q[$];
	logic [31:0] v;
	command_table_descriptor_walker i_dut (.*);
	walker_host_model i_host (
		.clk_in(clk_in),
		.mem_req_in(mem_req_out),
		.mem_addr_in(mem_addr_out),
		.mem_rvalid_out(mem_rvalid_in),
		.mem_rdata_out(mem_rdata_in),
		.tx_valid_in(tx_valid_out),
		.tx_last_in(tx_last_out),
		.tx_ready_out(tx_ready_in),
		.pio_req_out(pio_req_in),
		.pio_len_out(pio_len_in),
		.xfer_start_in(xfer_start_out),
		.xfer_done_out(xfer_done_in)
	);
	always #5 clk_in = ~clk_in;
	// ==========================================================
	// checks and register access
	task check(input string what, input logic [87:0] exp, input logic [87:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task report_and_stop;
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : report_and_stop
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr_reg
	task rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1 d = reg_rdata_out;
	endtask : rd_reg
	// ==========================================================
	// monitors
	always @(posedge clk_in) begin
		if (!reset_in && tx_valid_out && tx_ready_in)
			check("tx word", tx_q.size() != 0 ? tx_q.pop_front() : 'x, {tx_last_out, tx_data_out});
		if (!reset_in && xfer_start_out) begin
			check("block", xf_q.size() != 0 ? xf_q.pop_front() : 'x,
				{xfer_to_drive_out, xfer_len_out, xfer_addr_out});
		end
	end
	// ==========================================================
	// one command: build table, start, wait, compare
	task automatic run_cmd(input int n, input bit pkt, input bit wr, input bit wide,
			input int flen, input bit big);
		logic [63:0] base, a;
		logic [31:0] lo, hi, info, blo, bhi, tally, st, hdr;
		bit ioc, en;
		int i, plen;
		lo = $urandom();
		hi = $urandom();
		en = $urandom_range(1, 0) == 1;
		base = {wide ? hi : 32'h0, lo[31:7], 7'h00};
		for (i = 0; i < flen; i++) begin
			st = $urandom();
			i_host.mem[base + walker_pkg::FRAME_OFFSET + 64'(i * 4)] = st;
			tx_q.push_back({i == flen - 1, st});
		end
		plen = $urandom_range(1, 0) == 1 ? 16 : 12;
		for (i = 0; i < 4 && pkt; i++) begin
			st = $urandom();
			i_host.mem[base + walker_pkg::PACKET_OFFSET + 64'(i * 4)] = st;
			if (i < plen / 4) tx_q.push_back({i == plen / 4 - 1, st});
		end
		i_host.pkt_en = pkt;
		i_host.pkt_len = plen[4:0];
		i_host.frames = 0;
		tally = 32'h0;
		ioc = 1'b0;
		for (i = 0; i < n; i++) begin
			blo = $urandom();
			bhi = $urandom();
			info = $urandom_range(1023, 0) | 32'h1;
			info[31] = $urandom_range(1, 0) == 1;
			if (big && i == 0) info[21:0] = 22'h3FFFFF;
			a = base + walker_pkg::LIST_OFFSET + 64'(i * 16);
			i_host.mem[a] = blo;
			i_host.mem[a + 64'h4] = bhi;
			i_host.mem[a + 64'h8] = $urandom();
			i_host.mem[a + 64'hC] = info;
			xf_q.push_back({wr, info[21:0] + 23'h1, wide ? bhi : 32'h0, blo[31:1], 1'b0});
			tally += info[21:0] + 32'h1;
			ioc |= info[31];
		end
		wr_reg(walker_pkg::REG_CTRL, {29'h0, en, wide, 1'b0});
		hdr = {n[15:0], 9'h000, wr, pkt, flen[4:0]};
		wr_reg(walker_pkg::REG_HEADER0, hdr);
		wr_reg(walker_pkg::REG_TABLE_LOW, lo);
		wr_reg(walker_pkg::REG_TABLE_HIGH, hi);
		wr_reg(walker_pkg::REG_CTRL, {29'h0, en, wide, 1'b1});
		if (big) wr_reg(walker_pkg::REG_HEADER0, 32'h0);
		st = 32'h0;
		for (i = 0; i < 3000 && st[walker_pkg::STAT_DONE_BIT] !== 1'b1; i++)
			rd_reg(walker_pkg::REG_STATUS, st);
		check("done", 64'h1, st[walker_pkg::STAT_DONE_BIT]);
		check("busy", 64'h0, task_file_busy_flag_out);
		check("left over", 64'h0, tx_q.size() + xf_q.size());
		rd_reg(walker_pkg::REG_TALLY, st);
		check("tally reg", tally, st);
		check("tally out", tally, transferred_byte_tally_out);
		check("dps", ioc, descriptor_processed_status_out);
		check("irq", ioc & en, dps_irq_out);
		rd_reg(walker_pkg::REG_HEADER0, st);
		check("header kept", hdr, st);
		rd_reg(walker_pkg::REG_ENTRY_INDEX, st);
		check("last index", 64'(n == 0 ? 0 : n - 1), st);
		rd_reg(walker_pkg::REG_CTRL, st);
		check("ctrl", {en, wide, 1'b0}, st);
		wr_reg(walker_pkg::REG_STATUS, 32'h0000000C);
		rd_reg(walker_pkg::REG_STATUS, st);
		check("status cleared", 64'h0, st);
		$display("command with %0d entries finished", n);
	endtask : run_cmd
	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(32'h842f));
		repeat (5) @(posedge clk_in);
		reset_in <= 1'b0;
		rd_reg(walker_pkg::REG_STATUS, v);
		check("status reset", 64'h0, v);
		rd_reg(walker_pkg::REG_TALLY, v);
		check("tally reset", 64'h0, v);
		rd_reg(8'hFC, v);
		check("unmapped", 64'h0, v);
		$display("reset values finished");
		run_cmd(0, 1'b0, 1'b0, 1'b0, 2, 1'b0);
		run_cmd(2, 1'b1, 1'b1, 1'b1, 16, 1'b1);
		run_cmd(1, 1'b1, 1'b0, 1'b0, 5, 1'b0);
		for (int k = 0; k < 8; k++)
			run_cmd($urandom_range(5, 0), $urandom_range(1, 0) == 1, $urandom_range(1, 0) == 1,
				$urandom_range(1, 0) == 1, $urandom_range(16, 2), 1'b0);
		report_and_stop();
	end
	initial begin
		repeat (100000) @(posedge clk_in);
		num_errors++;
		report_and_stop();
	end
endmodule : command_table_descriptor_walker_bench
